// ==== core/lane_defs.vh ====
`ifndef LANE_DEFS_VH
`define LANE_DEFS_VH
// lane modes
`define MODE_RX 2'h0
`define MODE_TX 2'h1
`define MODE_BIDIR 2'h2
// word geometry
`define WORD_W 10
`define WIDTH_W 4
`define WIDTH_MAX 4'ha
// delay chain
`define TAP_W 4
`define TAP_MAX 4'hf
`define TAP_RESET 4'h0
// phase alignment training: stable bits needed for lock
`define LOCK_RUN 6'h20
// receive queue
`define QUEUE_DEPTH 8
`define QUEUE_AW 3
`endif

// ==== core/rx_queue.v ====
`timescale 1ns/100ps
`include "lane_defs.vh"
// eight-word queue between word-clock pushes and read-clock pops
module rx_queue (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire push,
  input wire [`WORD_W-1:0] push_data,
  input wire pop,
  output reg [`WORD_W-1:0] pop_data,
  output reg pop_valid,
  output reg empty
);
  reg [`WORD_W-1:0] mem [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_AW-1:0] wr_ptr;
  reg [`QUEUE_AW-1:0] rd_ptr;
  reg [`QUEUE_AW:0] count;
  wire full;
  wire do_push;
  wire do_pop;
  wire [`QUEUE_AW:0] next_count;

  assign full = (count == `QUEUE_DEPTH);
  // a push into a full queue is dropped, a pop from an empty one ignored
  assign do_push = push & ~full;
  assign do_pop = pop & (count != 0);
  assign next_count = count + {{`QUEUE_AW{1'b0}}, do_push} - {{`QUEUE_AW{1'b0}}, do_pop};

  // storage has no reset; the pointers define what is valid
  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= push_data;
  end

  // pointers, count and registered read port
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count <= 4'h0;
      pop_data <= 10'h000;
      pop_valid <= 1'b0;
      empty <= 1'b1;
    end
    else if (clear)
    begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count <= 4'h0;
      pop_valid <= 1'b0;
      empty <= 1'b1;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 3'h1;
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 3'h1;
        pop_data <= mem[rd_ptr];
      end
      pop_valid <= do_pop;
      count <= next_count;
      empty <= (next_count == 0);
    end
  end
endmodule // rx_queue

// ==== core/phase_align.v ====
`timescale 1ns/100ps
`include "lane_defs.vh"
// delay-chain setting: manual stepping or automatic phase training
module phase_align (
  input wire clk,
  input wire rst_n,
  input wire align_mode,
  input wire word_tick,
  input wire bit_tick,
  input wire step_enable,
  input wire step_dir,
  input wire clear,
  input wire early_bit,
  input wire late_bit,
  output reg [`TAP_W-1:0] tap,
  output reg locked
);
  localparam IDLE = 2'h0;
  localparam TRAIN = 2'h1;
  localparam LOCK = 2'h2;
  reg [1:0] state;
  reg [5:0] run;

  // controls are sampled only on word-clock edges
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= IDLE;
      tap <= `TAP_RESET;
      run <= 6'h00;
      locked <= 1'b0;
    end
    else if (word_tick && clear)
    begin
      // clears whichever function is configured
      state <= IDLE;
      tap <= `TAP_RESET;
      run <= 6'h00;
      locked <= 1'b0;
    end
    else if (!align_mode)
    begin
      state <= IDLE;
      locked <= 1'b0;
      // direction is ignored while training owns the tap
      if (word_tick && step_enable)
      begin
        if (step_dir && tap != `TAP_MAX)
          tap <= tap + 4'h1;
        else if (!step_dir && tap != `TAP_RESET)
          tap <= tap - 4'h1;
      end
    end
    else
    begin
      case (state)
        IDLE:
        begin
          run <= 6'h00;
          if (word_tick && step_enable)
            state <= TRAIN;
        end
        TRAIN:
        begin
          // a disagreement between neighbouring taps means an edge is near
          if (bit_tick && early_bit != late_bit)
          begin
            run <= 6'h00;
            tap <= tap + 4'h1;
          end
          else if (bit_tick)
          begin
            if (run == `LOCK_RUN - 6'h01)
            begin
              state <= LOCK;
              locked <= 1'b1;
            end
            run <= run + 6'h01;
          end
        end
        LOCK:
          locked <= 1'b1;
        default:
          state <= IDLE;
      endcase
    end
  end
endmodule // phase_align

// ==== core/lane_top.v ====
`timescale 1ns/100ps
`include "lane_defs.vh"
// How it works
// - received words leave in programmable width
// - alternate path only in width-one bypass
// - lock output shows trained phase alignment
// - queue empty flag falls on word clock push, rises on read clock pop
// - receive reset clears queue and deserializer
// - buffer enable gates the receiver
// - termination follows control in dynamic mode
// - step enable drives delay or training
// - direction steps delay up or down
// - delay clear resets delay or training
// - words presented on word clock rise, or on read clock rise when the queue is enabled
// - transmit word captured on word clock rise
// - transmit reset sampled on word clock
// - pads driven only under output enable, except in transmit-only with OE_USED low
// - transmit serial data or reference clock
// - full rate one edge, half both
// - eight-word queue crosses to read clock
module lane_top (
  input wire SYS_CLK,
  input wire RSTN,
  input wire [1:0] LANE_MODE,
  input wire [3:0] WORD_WIDTH,
  input wire HALF_RATE,
  input wire BYPASS_MODE,
  input wire QUEUE_ENABLE,
  input wire ALIGN_MODE,
  input wire REFCLK_MODE,
  input wire OE_USED,
  input wire DYN_TERM_MODE,
  input wire STATIC_TERM,
  input wire RX_WORD_CLOCK,
  input wire RX_BIT_CLOCK,
  input wire RX_QUEUE_READ_CLOCK,
  input wire RX_QUEUE_READ,
  input wire RX_PATH_RESET,
  input wire RX_BUF_ENABLE,
  input wire TERM_CTRL,
  input wire DELAY_STEP_ENABLE,
  input wire DELAY_STEP_DIR,
  input wire DELAY_CLEAR,
  input wire TX_WORD_CLOCK,
  input wire TX_BIT_CLOCK,
  input wire TX_PATH_RESET,
  input wire TX_OUT_ENABLE,
  input wire [9:0] TX_DATA,
  input wire LANE_P_IN,
  input wire LANE_N_IN,
  output reg LANE_P_OUT,
  output reg LANE_N_OUT,
  output reg LANE_OE,
  output reg [9:0] RX_DATA,
  output reg ALTERNATE_CLOCK_PATH,
  output wire ALIGN_LOCKED,
  output wire RX_QUEUE_EMPTY,
  output reg TERM_ON,
  output reg RX_BUF_ON
);
  reg rx_word_d;
  reg rx_bit_d;
  reg rd_clk_d;
  reg tx_word_d;
  reg tx_bit_d;
  reg rx_held;
  reg [15:0] chain;
  reg [9:0] gather;
  reg [3:0] gather_pos;
  reg [9:0] tx_word;
  reg [3:0] tx_pos;
  reg tx_bit;
  wire rx_word_tick;
  wire rd_tick;
  wire rx_bit_tick;
  wire tx_word_tick;
  wire tx_bit_tick;
  wire rx_mode;
  wire tx_mode;
  wire rx_sample;
  wire [3:0] tap;
  wire locked;
  wire [9:0] width_mask;
  wire [9:0] queue_data;
  wire queue_valid;
  wire queue_empty;
  wire rx_release;
  wire rx_rst_n;
  wire [3:0] width_eff;
  wire late_bit;
  genvar i;

  assign rx_mode = (LANE_MODE == `MODE_RX) | (LANE_MODE == `MODE_BIDIR);
  assign tx_mode = (LANE_MODE == `MODE_TX) | (LANE_MODE == `MODE_BIDIR);
  // widths of 0 or above ten are clamped to the legal range
  assign width_eff = (WORD_WIDTH == 4'h0) ? 4'h1 :
                     (WORD_WIDTH > `WIDTH_MAX) ? `WIDTH_MAX : WORD_WIDTH;

  // one bit of mask per lane bit below the configured width
  generate
    for (i = 0; i < `WORD_W; i = i + 1)
    begin : g_mask
      assign width_mask[i] = (i < width_eff);
    end
  endgenerate

  // clock inputs are sampled levels; edges become one-cycle ticks
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_word_d <= 1'b0;
      rx_bit_d <= 1'b0;
      rd_clk_d <= 1'b0;
      tx_word_d <= 1'b0;
      tx_bit_d <= 1'b0;
    end
    else
    begin
      rx_word_d <= RX_WORD_CLOCK;
      rx_bit_d <= RX_BIT_CLOCK;
      rd_clk_d <= RX_QUEUE_READ_CLOCK;
      tx_word_d <= TX_WORD_CLOCK;
      tx_bit_d <= TX_BIT_CLOCK;
    end
  end

  // each direction has its own clock pair
  assign rx_word_tick = RX_WORD_CLOCK & ~rx_word_d;
  assign tx_word_tick = TX_WORD_CLOCK & ~tx_word_d;
  assign rd_tick = RX_QUEUE_READ_CLOCK & ~rd_clk_d;
  // half rate samples both edges of the bit clock
  assign rx_bit_tick = (RX_BIT_CLOCK ^ rx_bit_d) & (HALF_RATE | RX_BIT_CLOCK);
  assign tx_bit_tick = (TX_BIT_CLOCK ^ tx_bit_d) & (HALF_RATE | TX_BIT_CLOCK);

  // receive reset: async assert, release on the owning clock edge
  assign rx_rst_n = RSTN & ~RX_PATH_RESET;
  assign rx_release = QUEUE_ENABLE ? rd_tick : rx_word_tick;
  always @(posedge SYS_CLK or negedge rx_rst_n)
  begin
    if (!rx_rst_n)
      rx_held <= 1'b1;
    else if (rx_release)
      rx_held <= 1'b0;
  end

  // input buffer: off means the lane reads as constant zero
  assign rx_sample = rx_mode & RX_BUF_ENABLE & LANE_P_IN & ~LANE_N_IN;

  // delay chain: tap k sees the pad k+1 cycles late
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      chain <= 16'h0000;
    else
      chain <= {chain[14:0], rx_sample};
  end
  assign late_bit = (tap == `TAP_MAX) ? chain[tap] : chain[tap + 4'h1];

  // training is only meaningful at full rate, so it is trusted here
  phase_align u_align (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .align_mode(ALIGN_MODE),
    .word_tick(rx_word_tick),
    .bit_tick(rx_bit_tick),
    .step_enable(DELAY_STEP_ENABLE),
    .step_dir(DELAY_STEP_DIR),
    .clear(DELAY_CLEAR),
    .early_bit(chain[tap]),
    .late_bit(late_bit),
    .tap(tap),
    .locked(locked)
  );
  assign ALIGN_LOCKED = ALIGN_MODE & locked;

  // deserializer: first bit lands on bit 0; word clock closes the word
  always @(posedge SYS_CLK or negedge rx_rst_n)
  begin
    if (!rx_rst_n)
    begin
      gather <= 10'h000;
      gather_pos <= 4'h0;
    end
    else if (rx_held)
    begin
      gather <= 10'h000;
      gather_pos <= 4'h0;
    end
    else if (rx_word_tick)
    begin
      // word boundaries hold only if word rate is bit rate over width
      gather <= {9'h000, rx_bit_tick & chain[tap]};
      gather_pos <= rx_bit_tick ? 4'h1 : 4'h0;
    end
    else if (rx_bit_tick && gather_pos < width_eff)
    begin
      gather[gather_pos] <= chain[tap];
      gather_pos <= gather_pos + 4'h1;
    end
  end

  // eight-word queue toward the read clock
  rx_queue u_queue (
    .clk(SYS_CLK),
    .rst_n(rx_rst_n),
    .clear(rx_held),
    .push(QUEUE_ENABLE & rx_word_tick & ~rx_held),
    .push_data(gather & width_mask),
    .pop(QUEUE_ENABLE & rd_tick & RX_QUEUE_READ),
    .pop_data(queue_data),
    .pop_valid(queue_valid),
    .empty(queue_empty)
  );
  // a pop on an empty queue is refused, never returns stale data
  assign RX_QUEUE_EMPTY = queue_empty | ~QUEUE_ENABLE;

  // parallel output: direct on word clock rise, or from the queue
  always @(posedge SYS_CLK or negedge rx_rst_n)
  begin
    if (!rx_rst_n)
      RX_DATA <= 10'h000;
    else if (rx_held)
      RX_DATA <= 10'h000;
    else if (!QUEUE_ENABLE && rx_word_tick)
      RX_DATA <= gather & width_mask;
    else if (QUEUE_ENABLE && queue_valid)
      RX_DATA <= queue_data;
  end

  // receive-side status and the bypass tap
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ALTERNATE_CLOCK_PATH <= 1'b0;
      TERM_ON <= 1'b0;
      RX_BUF_ON <= 1'b0;
    end
    else
    begin
      ALTERNATE_CLOCK_PATH <= BYPASS_MODE & (width_eff == 4'h1) & chain[tap];
      TERM_ON <= DYN_TERM_MODE ? TERM_CTRL : STATIC_TERM;
      RX_BUF_ON <= rx_mode & RX_BUF_ENABLE;
    end
  end

  // serializer: capture on word rise, shift out first bit first
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tx_word <= 10'h000;
      tx_pos <= 4'h0;
      tx_bit <= 1'b0;
    end
    else if (tx_word_tick && TX_PATH_RESET)
    begin
      tx_word <= 10'h000;
      tx_pos <= 4'h0;
      tx_bit <= 1'b0;
    end
    else if (tx_word_tick)
    begin
      // the other direction uses the same width in bidirectional mode
      tx_word <= TX_DATA & width_mask;
      tx_pos <= 4'h0;
    end
    else if (tx_bit_tick)
    begin
      if (REFCLK_MODE)
        tx_bit <= TX_WORD_CLOCK;
      else
        tx_bit <= (tx_pos < width_eff) ? tx_word[tx_pos] : 1'b0;
      if (tx_pos < width_eff)
        tx_pos <= tx_pos + 4'h1;
    end
  end

  // pad drive: enable optional in transmit-only, required in bidirectional
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LANE_P_OUT <= 1'b0;
      LANE_N_OUT <= 1'b1;
      LANE_OE <= 1'b0;
    end
    else
    begin
      LANE_P_OUT <= tx_bit;
      LANE_N_OUT <= ~tx_bit;
      if (!tx_mode)
        LANE_OE <= 1'b0;
      else if (LANE_MODE == `MODE_TX)
        LANE_OE <= ~OE_USED | TX_OUT_ENABLE;
      else
        LANE_OE <= TX_OUT_ENABLE;
    end
  end
endmodule // lane_top

// ==== test/lane_checks_props.sv ====
`timescale 1ns/100ps
`include "lane_defs.vh"
// pin-level relations of the lane, watched from outside
module lane_checks (
  input wire SYS_CLK,
  input wire RSTN,
  input wire [1:0] LANE_MODE,
  input wire [3:0] WORD_WIDTH,
  input wire BYPASS_MODE,
  input wire QUEUE_ENABLE,
  input wire ALIGN_MODE,
  input wire OE_USED,
  input wire DYN_TERM_MODE,
  input wire STATIC_TERM,
  input wire RX_WORD_CLOCK,
  input wire RX_PATH_RESET,
  input wire DELAY_CLEAR,
  input wire RX_BUF_ENABLE,
  input wire TERM_CTRL,
  input wire TX_OUT_ENABLE,
  input wire LANE_P_OUT,
  input wire LANE_N_OUT,
  input wire LANE_OE,
  input wire [9:0] RX_DATA,
  input wire ALTERNATE_CLOCK_PATH,
  input wire ALIGN_LOCKED,
  input wire RX_QUEUE_EMPTY,
  input wire TERM_ON,
  input wire RX_BUF_ON
);
  reg word_seen;
  wire word_tick;
  // previous word clock level, so a rise can be told apart from a level
  always @(posedge SYS_CLK or negedge RSTN)
    if (!RSTN)
      word_seen <= 1'h0;
    else
      word_seen <= RX_WORD_CLOCK;
  assign word_tick = RX_WORD_CLOCK & ~word_seen;
  // sampled reset in antecedents keeps the release edge out of reach
  default clocking chk_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  buf_enable_a: assert property (RSTN |=> RX_BUF_ON ==
    ($past(LANE_MODE) != `MODE_TX && $past(RX_BUF_ENABLE))) else $error("rx buffer state");
  term_follow_a: assert property (RSTN |=> TERM_ON ==
    ($past(DYN_TERM_MODE) ? $past(TERM_CTRL) : $past(STATIC_TERM))) else $error("termination");
  alt_bypass_a: assert property (RSTN && (!BYPASS_MODE || WORD_WIDTH > 4'h1)
    |=> !ALTERNATE_CLOCK_PATH) else $error("alternate path outside bypass");
  lock_gate_a: assert property (!ALIGN_MODE |-> !ALIGN_LOCKED) else $error("lock");
  empty_off_a: assert property (!QUEUE_ENABLE |-> RX_QUEUE_EMPTY) else $error("empty");
  oe_bidir_a: assert property (RSTN && !TX_OUT_ENABLE && LANE_MODE == `MODE_BIDIR
    |=> !LANE_OE) else $error("bidir pads driven");
  oe_rx_a: assert property (RSTN && LANE_MODE == `MODE_RX |=> !LANE_OE)
    else $error("rx lane drives pads");
  oe_free_a: assert property (RSTN && LANE_MODE == `MODE_TX && !OE_USED |=> LANE_OE)
    else $error("tx pads not driven");
  pads_diff_a: assert property (LANE_N_OUT == !LANE_P_OUT) else $error("pads");
  word_time_a: assert property (!QUEUE_ENABLE && $changed(RX_DATA) && !RX_PATH_RESET
    |-> $past(word_tick) || $past(RX_PATH_RESET)) else $error("word off the word clock");
  rx_clear_a: assert property (RSTN && RX_PATH_RESET |=> RX_QUEUE_EMPTY
    && RX_DATA == 10'h0) else $error("rx reset");
  lock_clear_a: assert property (RSTN && word_tick && DELAY_CLEAR |=> !ALIGN_LOCKED)
    else $error("lock kept after clear");
  empty_hold_a: assert property (RSTN && QUEUE_ENABLE && RX_QUEUE_EMPTY && !word_tick
    |=> RX_QUEUE_EMPTY) else $error("queue filled without a word");
endmodule // lane_checks

// ==== test/serial_peer.sv ====
`timescale 1ns/100ps
// far-end serial source: drives receive pads and their word and bit clocks
module serial_peer (
  input wire clk,
  output reg pad_p,
  output reg pad_n,
  output reg bit_clock,
  output reg word_clock
);
  // clocks stand low outside frames
  initial
  begin
    pad_p = 1'h0;
    pad_n = 1'h1;
    bit_clock = 1'h0;
    word_clock = 1'h0;
  end
  task edges(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // word clock pulse, wide enough to be seen as a rise
  task strobe;
    begin
      word_clock <= 1'h1;
      edges(2);
      word_clock <= 1'h0;
      edges(2);
    end
  endtask
  // bit held steady around a rising-only pulse, so delay taps see one value
  task put_bit(input v);
    begin
      pad_p <= v;
      pad_n <= ~v;
      edges(2);
      bit_clock <= 1'h1;
      edges(2);
      bit_clock <= 1'h0;
      edges(2);
    end
  endtask
  task train(input v, input integer n);
    repeat (n) put_bit(v);
  endtask
  // half rate: every bit clock edge carries one bit
  task put_edge(input v);
    begin
      pad_p <= v;
      pad_n <= ~v;
      edges(2);
      bit_clock <= ~bit_clock;
      edges(2);
    end
  endtask
  // pad level change with no bit clock, for delay-tap timing
  task set_pad(input v);
    begin
      pad_p <= v;
      pad_n <= ~v;
    end
  endtask
  // bits since the last word rise, closed by one word rise
  task send(input integer w, input [9:0] d, input half);
    integer i;
    begin
      for (i = 0; i < w; i = i + 1)
        if (half)
          put_edge(d[i]);
        else
          put_bit(d[i]);
      strobe;
      pad_p <= ~pad_p;
      pad_n <= pad_p;
    end
  endtask
endmodule // serial_peer

// ==== test/tb.sv ====
`timescale 1ns/100ps
`include "lane_defs.vh"
module tb;
  reg SYS_CLK, RSTN = 1'h0, HALF_RATE = 1'h0, BYPASS_MODE = 1'h0, QUEUE_ENABLE = 1'h0;
  reg ALIGN_MODE = 1'h0, REFCLK_MODE = 1'h0, OE_USED = 1'h0, DYN_TERM_MODE = 1'h0;
  reg STATIC_TERM = 1'h0, RX_QUEUE_READ_CLOCK = 1'h0, RX_QUEUE_READ = 1'h0, RX_PATH_RESET = 1'h0;
  reg RX_BUF_ENABLE = 1'h0, TERM_CTRL = 1'h0, DELAY_STEP_ENABLE = 1'h0, DELAY_STEP_DIR = 1'h0;
  reg DELAY_CLEAR = 1'h0, TX_WORD_CLOCK = 1'h0, TX_BIT_CLOCK = 1'h0, TX_PATH_RESET = 1'h0;
  reg TX_OUT_ENABLE = 1'h0;
  reg [1:0] LANE_MODE = `MODE_RX;
  reg [3:0] WORD_WIDTH = 4'ha;
  reg [9:0] TX_DATA = 10'h0;
  wire RX_WORD_CLOCK, RX_BIT_CLOCK, LANE_P_IN, LANE_N_IN, LANE_P_OUT, LANE_N_OUT, LANE_OE;
  wire ALTERNATE_CLOCK_PATH, ALIGN_LOCKED, RX_QUEUE_EMPTY, TERM_ON, RX_BUF_ON;
  wire [9:0] RX_DATA;
  integer n_fail = 0, num_checks = 0, i;
  lane_top u_lane_top (.SYS_CLK, .RSTN, .LANE_MODE, .WORD_WIDTH, .HALF_RATE, .BYPASS_MODE,
    .QUEUE_ENABLE, .ALIGN_MODE, .REFCLK_MODE, .OE_USED, .DYN_TERM_MODE, .STATIC_TERM,
    .RX_WORD_CLOCK, .RX_BIT_CLOCK, .RX_QUEUE_READ_CLOCK, .RX_QUEUE_READ, .RX_PATH_RESET,
    .RX_BUF_ENABLE, .TERM_CTRL, .DELAY_STEP_ENABLE, .DELAY_STEP_DIR, .DELAY_CLEAR,
    .TX_WORD_CLOCK, .TX_BIT_CLOCK, .TX_PATH_RESET, .TX_OUT_ENABLE, .TX_DATA, .LANE_P_IN,
    .LANE_N_IN, .LANE_P_OUT, .LANE_N_OUT, .LANE_OE, .RX_DATA, .ALTERNATE_CLOCK_PATH,
    .ALIGN_LOCKED, .RX_QUEUE_EMPTY, .TERM_ON, .RX_BUF_ON);
  serial_peer u_serial_peer (.clk(SYS_CLK), .pad_p(LANE_P_IN), .pad_n(LANE_N_IN),
    .bit_clock(RX_BIT_CLOCK), .word_clock(RX_WORD_CLOCK));
  // system clock, 100 ns
  initial
  begin
    SYS_CLK = 1'h0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  task automatic tick(input integer n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task check(input [63:0] name, input [9:0] seen, input [9:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task done(input [63:0] t);
    $display("test %0s done", t);
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // bits past the width must come back as zero
  task rx_case(input [3:0] w, input [9:0] d, input h);
    begin
      WORD_WIDTH <= w;
      HALF_RATE <= h;
      u_serial_peer.send(w, d, h);
      check("rx_word", RX_DATA, d & (10'h3ff >> (4'ha - w)));
    end
  endtask
  task read_tick;
    begin
      RX_QUEUE_READ_CLOCK <= 1'h1;
      tick(2);
      RX_QUEUE_READ_CLOCK <= 1'h0;
      tick(2);
    end
  endtask
  // one extra bit period checks the idle zero after the word
  task tx_send(input integer w, input [9:0] d);
    begin
      TX_DATA <= d;
      TX_WORD_CLOCK <= 1'h1;
      tick(2);
      TX_WORD_CLOCK <= 1'h0;
      for (i = 0; i <= w; i = i + 1)
      begin
        TX_BIT_CLOCK <= 1'h1;
        tick(2);
        TX_BIT_CLOCK <= 1'h0;
        tick(1);
        #1 check("tx_pad", LANE_P_OUT, (i < w) ? d[i] & ~TX_PATH_RESET : 1'h0);
        tick(1);
      end
    end
  endtask
  // main sequence
  initial
  begin
    tick(6);
    RSTN <= 1'h1;
    tick(2);
    check("empty", RX_QUEUE_EMPTY, 1'h1);
    check("oe", LANE_OE, 1'h0);
    u_serial_peer.strobe;
    for (i = 0; i < 4; i = i + 1)
    begin
      RX_BUF_ENABLE <= i[0];
      TERM_CTRL <= i[0];
      STATIC_TERM <= ~i[0];
      DYN_TERM_MODE <= i[1];
      tick(2);
      check("buf", RX_BUF_ON, i[0]);
      check("term", TERM_ON, {i[1] ~^ i[0]});
    end
    done("controls");
    BYPASS_MODE <= 1'h1;
    WORD_WIDTH <= 4'h1;
    u_serial_peer.train(1'h1, 1);
    check("alt", ALTERNATE_CLOCK_PATH, 1'h1);
    // manual delay: three steps up, then one down, seen as pad delay
    DELAY_STEP_ENABLE <= 1'h1;
    DELAY_STEP_DIR <= 1'h1;
    repeat (3) u_serial_peer.strobe;
    DELAY_STEP_ENABLE <= 1'h0;
    u_serial_peer.set_pad(1'h0);
    tick(5);
    check("tap_up", ALTERNATE_CLOCK_PATH, 1'h1);
    tick(2);
    check("tap_up", ALTERNATE_CLOCK_PATH, 1'h0);
    DELAY_STEP_ENABLE <= 1'h1;
    DELAY_STEP_DIR <= 1'h0;
    u_serial_peer.strobe;
    DELAY_STEP_ENABLE <= 1'h0;
    u_serial_peer.set_pad(1'h1);
    tick(4);
    check("tap_dn", ALTERNATE_CLOCK_PATH, 1'h0);
    tick(1);
    check("tap_dn", ALTERNATE_CLOCK_PATH, 1'h1);
    WORD_WIDTH <= 4'h2;
    tick(2);
    check("alt", ALTERNATE_CLOCK_PATH, 1'h0);
    BYPASS_MODE <= 1'h0;
    done("bypass");
    ALIGN_MODE <= 1'h1;
    DELAY_STEP_ENABLE <= 1'h1;
    u_serial_peer.strobe;
    DELAY_STEP_ENABLE <= 1'h0;
    u_serial_peer.train(1'h1, 30);
    check("lock", ALIGN_LOCKED, 1'h0);
    u_serial_peer.train(1'h1, 6);
    check("lock", ALIGN_LOCKED, 1'h1);
    DELAY_CLEAR <= 1'h1;
    u_serial_peer.strobe;
    DELAY_CLEAR <= 1'h0;
    check("lock", ALIGN_LOCKED, 1'h0);
    ALIGN_MODE <= 1'h0;
    done("align");
    rx_case(4'ha, 10'h2b5, 1'h0);
    rx_case(4'h4, 10'h009, 1'h1);
    rx_case(4'h3, 10'h3fd, 1'h0);
    done("width");
    QUEUE_ENABLE <= 1'h1;
    WORD_WIDTH <= 4'h8;
    RX_PATH_RESET <= 1'h1;
    tick(2);
    check("rx_clear", RX_DATA, 10'h0);
    RX_PATH_RESET <= 1'h0;
    read_tick;
    u_serial_peer.send(8, 10'h0a5, 1'h0);
    tick(2);
    check("empty", RX_QUEUE_EMPTY, 1'h0);
    RX_QUEUE_READ <= 1'h1;
    read_tick;
    RX_QUEUE_READ <= 1'h0;
    tick(2);
    check("q_word", RX_DATA, 10'h0a5);
    check("empty", RX_QUEUE_EMPTY, 1'h1);
    done("queue");
    LANE_MODE <= `MODE_TX;
    OE_USED <= 1'h1;
    TX_OUT_ENABLE <= 1'h1;
    WORD_WIDTH <= 4'h4;
    tick(2);
    check("buf", RX_BUF_ON, 1'h0);
    tx_send(4, 10'h01a);
    check("oe", LANE_OE, 1'h1);
    TX_PATH_RESET <= 1'h1;
    tx_send(4, 10'h3ff);
    TX_PATH_RESET <= 1'h0;
    // reference clock: pad follows the word clock level at each bit tick
    REFCLK_MODE <= 1'h1;
    TX_WORD_CLOCK <= 1'h1;
    tick(2);
    TX_BIT_CLOCK <= 1'h1;
    tick(2);
    TX_BIT_CLOCK <= 1'h0;
    TX_WORD_CLOCK <= 1'h0;
    tick(2);
    check("refclk", LANE_P_OUT, 1'h1);
    TX_BIT_CLOCK <= 1'h1;
    tick(2);
    TX_BIT_CLOCK <= 1'h0;
    tick(2);
    check("refclk", LANE_P_OUT, 1'h0);
    REFCLK_MODE <= 1'h0;
    TX_OUT_ENABLE <= 1'h0;
    tick(2);
    check("oe", LANE_OE, 1'h0);
    OE_USED <= 1'h0;
    tick(2);
    check("oe", LANE_OE, 1'h1);
    LANE_MODE <= `MODE_BIDIR;
    tick(2);
    check("oe", LANE_OE, 1'h0);
    done("tx");
    results;
  end
  // hang guard, far beyond the roughly five hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    n_fail = n_fail + 1;
    results;
  end
endmodule // tb
bind lane_top lane_checks u_lane_checks (.SYS_CLK, .RSTN, .LANE_MODE, .WORD_WIDTH,
  .BYPASS_MODE, .QUEUE_ENABLE, .ALIGN_MODE, .OE_USED, .DYN_TERM_MODE, .STATIC_TERM,
  .RX_WORD_CLOCK, .RX_PATH_RESET, .DELAY_CLEAR, .RX_BUF_ENABLE, .TERM_CTRL, .TX_OUT_ENABLE,
  .LANE_P_OUT,
  .LANE_N_OUT, .LANE_OE, .RX_DATA, .ALTERNATE_CLOCK_PATH, .ALIGN_LOCKED, .RX_QUEUE_EMPTY,
  .TERM_ON, .RX_BUF_ON);
